// [hdl/dcmc_pkg.sv]
// Package for the duplex core memory control block.
// Assumes a single 100 MHz clock domain and no software register bus.
package dcmc_pkg;

    // ------------------------------------------------------------------
    // Word format
    // ------------------------------------------------------------------
    localparam int WORD_W      = 28;
    localparam int DATA_W      = 26;
    localparam int DPAR_W      = 2;
    localparam int INSTR_W     = 13;
    localparam int ADDR_W      = 15;
    localparam int MEM_WORDS   = 32768;
    localparam int DPAR0_POS   = 26;
    localparam int DPAR1_POS   = 27;
    localparam int IPAR_POS    = 13;
    localparam int SYL_HI_POS  = 14;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int    CLK_MHZ      = 100;
    localparam real   CLK_TIME_US  = 0.49;
    localparam real   BIT_TIME_US  = 1.95;
    localparam real   CYCLE_TIME_US = 82.03;
    localparam int    BIT_RATE_BPS = 512000;
    localparam int    CLK_PHASE_CYC = int'($floor(CLK_TIME_US * CLK_MHZ));
    localparam int    BIT_CYC      = int'($floor(BIT_TIME_US * CLK_MHZ));
    localparam int    CYCLE_CYC    = int'($floor(CYCLE_TIME_US * CLK_MHZ));
    localparam int    BITS_PER_CYCLE = CYCLE_CYC / BIT_CYC;

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DCMC_IDLE  = 3'b000,
        DCMC_READ  = 3'b001,
        DCMC_SHIFT = 3'b010,
        DCMC_WRITE = 3'b011,
        DCMC_FIX   = 3'b100
    } dcmc_state_t;

endpackage : dcmc_pkg

// [hdl/dcmc_voter.sv]
// Bitwise triple-path majority voter.
// Assumes the three paths are on the same clock as the voter.
`timescale 1ns/10ps
module dcmc_voter #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] a_in,
    input  wire logic [W-1:0] b_in,
    input  wire logic [W-1:0] c_in,
    output logic      [W-1:0] vote_out,
    output logic              disagree_out
);

    // Each bit takes the value held by two or more paths.
    assign vote_out     = (a_in & b_in) | (a_in & c_in) | (b_in & c_in);
    assign disagree_out = |((a_in ^ b_in) | (a_in ^ c_in));

endmodule : dcmc_voter

// [hdl/dcmc_top.sv]
// Duplex core memory controller with serial word transfer and TMR voting.
// Assumes the processor logic shares clk_in and holds requests stable
// until accepted by done_out.
//
// Functional notes
// - Memory word 28 bits, data 26 plus two parity.
// - Instruction is 13 bits plus one parity.
// - Each module holds 32768 words of 28 bits.
// - Words shift serially at 512000 bits per second.
// - Clock, bit and computer cycle timing derived.
// - Separate data and instruction addressing paths.
// - Duplex writes store identical word in both modules.
// - Duplex read error uses mate word, rewrites.
// - Simplex modules distinct, doubled capacity, no correction.
// - Processor selects simplex or duplex by program.
// - Add unit and multiply unit run concurrently.
// - Triplicated control paths are voted; here only the controller state is triplicated and voted.
`timescale 1ns/10ps
module dcmc_top (
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    input  wire logic                          duplex_in,
    input  wire logic                          req_in,
    input  wire logic                          we_in,
    input  wire logic                          instr_in,
    input  wire logic                          bank_in,
    input  wire logic [dcmc_pkg::ADDR_W-1:0]   daddr_in,
    input  wire logic [dcmc_pkg::ADDR_W-1:0]   iaddr_in,
    input  wire logic [dcmc_pkg::WORD_W-1:0]   wdata_in,
    input  wire logic [dcmc_pkg::DATA_W-1:0]   add_a_in,
    input  wire logic [dcmc_pkg::DATA_W-1:0]   add_b_in,
    input  wire logic                          add_sub_in,
    input  wire logic [12:0]                   mul_a_in,
    input  wire logic [12:0]                   mul_b_in,
    output logic                               done_out,
    output logic [dcmc_pkg::WORD_W-1:0]        rdata_out,
    output logic                               rbit_out,
    output logic                               rbit_valid_out,
    output logic                               err_out,
    output logic                               fixed_out,
    output logic                               duplex_out,
    output logic                               bit_tick_out,
    output logic [dcmc_pkg::DATA_W-1:0]        add_out,
    output logic [dcmc_pkg::DATA_W-1:0]        mul_out,
    output logic                               tmr_err_out
);

    // ------------------------------------------------------------------
    // Parity helpers
    // ------------------------------------------------------------------

    // Checks both parity fields of a data word, or the single field of an instruction word (odd parity).
    function automatic logic parity_ok(input logic [dcmc_pkg::WORD_W-1:0] w,
                                       input logic is_instr);
        if (is_instr)
            return ^w[dcmc_pkg::IPAR_POS:0];
        return (^{w[12:0], w[dcmc_pkg::DPAR0_POS]})
             & (^{w[25:13], w[dcmc_pkg::DPAR1_POS]});
    endfunction : parity_ok

    // ------------------------------------------------------------------
    // Storage and timing
    // ------------------------------------------------------------------
    localparam int BIT_W = 8;
    localparam int CNT_W = 5;
    localparam logic [BIT_W-1:0] BIT_LAST  = BIT_W'(dcmc_pkg::BIT_CYC - 1);
    localparam logic [CNT_W-1:0] WORD_LAST = CNT_W'(dcmc_pkg::WORD_W - 1);

    logic [dcmc_pkg::WORD_W-1:0] mem_a [dcmc_pkg::MEM_WORDS];
    logic [dcmc_pkg::WORD_W-1:0] mem_b [dcmc_pkg::MEM_WORDS];

    dcmc_pkg::dcmc_state_t       state [3];
    dcmc_pkg::dcmc_state_t       next_state;
    logic [BIT_W-1:0]            bit_cnt;
    logic [CNT_W-1:0]            shift_cnt;
    logic [dcmc_pkg::ADDR_W-1:0] addr;
    logic                        instr;
    logic                        bank;
    logic                        mode;
    logic [dcmc_pkg::WORD_W-1:0] word_a;
    logic [dcmc_pkg::WORD_W-1:0] word_b;
    logic [dcmc_pkg::WORD_W-1:0] shreg;
    logic                        bad_a;
    logic                        bad_b;
    logic [2:0]                  vote_state;
    logic                        st_dis;
    logic                        tick;
    logic                        loaded;

    // Majority vote of the three copies of the controller state.
    dcmc_voter #(.W(3)) u_vote (
        .a_in         (state[0]),
        .b_in         (state[1]),
        .c_in         (state[2]),
        .vote_out     (vote_state),
        .disagree_out (st_dis)
    );

    assign tick = (bit_cnt == BIT_LAST);

    // Bit-time generator for the serial shift rate.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            bit_cnt <= '0;
        else if (tick)
            bit_cnt <= '0;
        else
            bit_cnt <= bit_cnt + 1'b1;
    end

    // Next-state logic computed from the voted state.
    always_comb
    begin
        next_state = dcmc_pkg::DCMC_IDLE;
        case (dcmc_pkg::dcmc_state_t'(vote_state))
            dcmc_pkg::DCMC_IDLE:
                if (req_in)
                    next_state = we_in ? dcmc_pkg::DCMC_WRITE
                                       : dcmc_pkg::DCMC_READ;
            dcmc_pkg::DCMC_READ:
                next_state = dcmc_pkg::DCMC_SHIFT;
            dcmc_pkg::DCMC_SHIFT:
                if (tick && shift_cnt == WORD_LAST)
                    next_state = (mode && (bad_a ^ bad_b))
                               ? dcmc_pkg::DCMC_FIX
                               : dcmc_pkg::DCMC_IDLE;
                else
                    next_state = dcmc_pkg::DCMC_SHIFT;
            default:
                next_state = dcmc_pkg::DCMC_IDLE;
        endcase
    end

    // Three state copies, each reloaded from the vote to scrub upsets.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state[0] <= dcmc_pkg::DCMC_IDLE;
            state[1] <= dcmc_pkg::DCMC_IDLE;
            state[2] <= dcmc_pkg::DCMC_IDLE;
        end
        else
        begin
            state[0] <= next_state;
            state[1] <= next_state;
            state[2] <= next_state;
        end
    end

    // Request capture with separate data and instruction address paths.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            addr  <= '0;
            instr <= 1'b0;
            bank  <= 1'b0;
            mode  <= 1'b0;
        end
        else if (vote_state == dcmc_pkg::DCMC_IDLE && req_in)
        begin
            addr  <= instr_in ? iaddr_in : daddr_in;
            instr <= instr_in;
            bank  <= bank_in;
            mode  <= duplex_in;
        end
    end

    // Core array access: reads both modules, writes per mode.
    always_ff @(posedge clk_in)
    begin
        if (vote_state == dcmc_pkg::DCMC_READ)
        begin
            word_a <= mem_a[addr];
            word_b <= mem_b[addr];
        end
        if (vote_state == dcmc_pkg::DCMC_WRITE)
        begin
            if (mode || !bank)
                mem_a[addr] <= wdata_in;
            if (mode || bank)
                mem_b[addr] <= wdata_in;
        end
        if (vote_state == dcmc_pkg::DCMC_FIX)
        begin
            if (bad_a)
                mem_a[addr] <= word_b;
            else
                mem_b[addr] <= word_a;
        end
    end

    assign bad_a = !parity_ok(word_a, instr);
    assign bad_b = !parity_ok(word_b, instr);

    // Serial readout: the word is taken in the first shift cycle, once the
    // array read has settled; a bit tick in that cycle is let pass, since
    // the free-running bit timer may fall anywhere against the request.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            shreg          <= '0;
            shift_cnt      <= '0;
            loaded         <= 1'b0;
            rbit_out       <= 1'b0;
            rbit_valid_out <= 1'b0;
        end
        else if (vote_state == dcmc_pkg::DCMC_READ)
        begin
            shift_cnt      <= '0;
            loaded         <= 1'b0;
            rbit_valid_out <= 1'b0;
        end
        else if (vote_state == dcmc_pkg::DCMC_SHIFT)
        begin
            if (!loaded)
            begin
                shreg  <= (mode ? (bad_a ? word_b : word_a)
                                : (bank ? word_b : word_a));
                loaded <= 1'b1;
            end
            rbit_valid_out <= tick && loaded;
            if (tick && loaded)
            begin
                rbit_out  <= shreg[shift_cnt];
                shift_cnt <= shift_cnt + 1'b1;
            end
        end
        else
            rbit_valid_out <= 1'b0;
    end

    // Completion pulse, parallel result and error flags.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            done_out  <= 1'b0;
            rdata_out <= '0;
            err_out   <= 1'b0;
            fixed_out <= 1'b0;
        end
        else
        begin
            done_out  <= (next_state == dcmc_pkg::DCMC_IDLE)
                       && (vote_state != dcmc_pkg::DCMC_IDLE);
            if (vote_state == dcmc_pkg::DCMC_SHIFT
                && next_state != dcmc_pkg::DCMC_SHIFT)
            begin
                rdata_out <= shreg;
                err_out   <= mode ? (bad_a & bad_b)
                                  : (bank ? bad_b : bad_a);
                fixed_out <= mode && (bad_a ^ bad_b);
            end
        end
    end

    // Two concurrent arithmetic units: add/subtract and multiply.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            add_out <= '0;
            mul_out <= '0;
        end
        else
        begin
            add_out <= add_sub_in ? add_a_in - add_b_in
                                  : add_a_in + add_b_in;
            mul_out <= mul_a_in * mul_b_in;
        end
    end

    // Status mirrors.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            duplex_out   <= 1'b0;
            bit_tick_out <= 1'b0;
            tmr_err_out  <= 1'b0;
        end
        else
        begin
            duplex_out   <= mode;
            bit_tick_out <= tick;
            tmr_err_out  <= st_dis;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_bit_period: assert property (tick |=> !tick [*8])
        else $error("bit tick too close");
    a_read_seq: assert property (vote_state == dcmc_pkg::DCMC_READ
        |=> vote_state == dcmc_pkg::DCMC_SHIFT)
        else $error("read not followed by shift");
    a_fix_mode: assert property (vote_state == dcmc_pkg::DCMC_FIX
        |-> mode)
        else $error("repair outside duplex");
    a_fix_fault: assert property (vote_state == dcmc_pkg::DCMC_FIX
        |-> bad_a != bad_b)
        else $error("repair without single fault");
    a_fix_flag: assert property (vote_state == dcmc_pkg::DCMC_FIX
        |=> fixed_out && done_out)
        else $error("repair not reported");
    a_mode_capt: assert property (vote_state == dcmc_pkg::DCMC_IDLE
        && req_in |=> mode == $past(duplex_in))
        else $error("mode not captured");
    a_addr_path: assert property (vote_state == dcmc_pkg::DCMC_IDLE
        && req_in && instr_in |=> addr == $past(iaddr_in))
        else $error("instruction address path wrong");
    a_tmr_agree: assert property (!st_dis |=> !tmr_err_out)
        else $error("tmr flag without disagreement");
    a_add_unit: assert property (!add_sub_in |=>
        add_out - $past(add_b_in) == $past(add_a_in))
        else $error("adder result wrong");

    c_write: cover property (vote_state == dcmc_pkg::DCMC_WRITE && mode);
    c_read:  cover property (done_out && !fixed_out);
    c_fix:   cover property (vote_state == dcmc_pkg::DCMC_FIX);
    c_simp:  cover property (vote_state == dcmc_pkg::DCMC_WRITE && !mode);

endmodule : dcmc_top

// [verif/dcmc_proc_model.sv]
// Processor-side model issuing word accesses to the memory controller.
// Assumes clk_in is shared and done_in ends each held request.
`timescale 1ns/10ps
module dcmc_proc_model (
    input  wire logic                        clk_in,
    input  wire logic                        done_in,
    input  wire logic                        rbit_in,
    input  wire logic                        rbit_valid_in,
    output logic                             duplex_out,
    output logic                             req_out,
    output logic                             we_out,
    output logic                             instr_out,
    output logic                             bank_out,
    output logic [dcmc_pkg::ADDR_W-1:0]      daddr_out,
    output logic [dcmc_pkg::ADDR_W-1:0]      iaddr_out,
    output logic [dcmc_pkg::WORD_W-1:0]      wdata_out
);
    logic [dcmc_pkg::WORD_W-1:0] bits;
    int                          nbits;
    logic                        timed_out;

    // Idle request lines at time zero.
    initial
    begin
        {duplex_out, req_out, we_out, instr_out, bank_out} = 5'h00;
        {daddr_out, iaddr_out, wdata_out} = '0;
        bits = '0;
        nbits = 0;
        timed_out = 1'b0;
    end

    // One access, held until done; serial bits are gathered meanwhile.
    task automatic access(input logic w, ins, bk, dup,
                          input logic [dcmc_pkg::ADDR_W-1:0] a,
                          input logic [dcmc_pkg::WORD_W-1:0] d);
        int n;
        @(posedge clk_in);
        #1;
        duplex_out = dup;
        we_out = w;
        instr_out = ins;
        bank_out = bk;
        daddr_out = ins ? ~a : a;
        iaddr_out = ins ? a : ~a;
        wdata_out = d;
        req_out = 1'b1;
        nbits = 0;
        timed_out = 1'b1;
        for (n = 0; n < 8000 && timed_out; n++)
        begin
            @(posedge clk_in);
            #1;
            if (rbit_valid_in === 1'b1)
            begin
                bits[nbits % 28] = rbit_in;
                nbits++;
            end
            if (done_in === 1'b1)
                timed_out = 1'b0;
        end
        // Released lines stop showing the old values.
        req_out = 1'b0;
        wdata_out = ~d;
        daddr_out = ~daddr_out;
        iaddr_out = ~iaddr_out;
    endtask : access
endmodule : dcmc_proc_model

// [verif/test_duplex_core_memory_control.sv]
// Self-checking bench for the duplex core memory controller.
// Assumes the processor model drives the processor side of the controller.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    n_mismatch++; $display("[ERR] %0t value differs", $time); end end
module test_duplex_core_memory_control;
    logic clk_in = 1'b0, resetn_in = 1'b0, add_sub_in = 1'b0;
    logic duplex, req, we, instr, bank, done, rbit, rbit_v, err, fixed;
    logic dup_o, tick, tmr_err;
    logic [14:0] daddr, iaddr;
    logic [27:0] wdata, rdata;
    logic [25:0] add_a_in = '0, add_b_in = '0, add_o, mul_o;
    logic [12:0] mul_a_in = '0, mul_b_in = '0;
    int          n_mismatch = 0, samples_checked = 0;

    // ------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------
    always #5 clk_in = ~clk_in;
    dcmc_top dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .duplex_in(duplex), .req_in(req), .we_in(we), .instr_in(instr),
        .bank_in(bank), .daddr_in(daddr), .iaddr_in(iaddr),
        .wdata_in(wdata), .add_a_in(add_a_in), .add_b_in(add_b_in),
        .add_sub_in(add_sub_in), .mul_a_in(mul_a_in), .mul_b_in(mul_b_in),
        .done_out(done), .rdata_out(rdata), .rbit_out(rbit),
        .rbit_valid_out(rbit_v), .err_out(err), .fixed_out(fixed),
        .duplex_out(dup_o), .bit_tick_out(tick), .add_out(add_o),
        .mul_out(mul_o), .tmr_err_out(tmr_err));
    dcmc_proc_model pm (.clk_in(clk_in), .done_in(done), .rbit_in(rbit),
        .rbit_valid_in(rbit_v), .duplex_out(duplex), .req_out(req),
        .we_out(we), .instr_out(instr), .bank_out(bank),
        .daddr_out(daddr), .iaddr_out(iaddr), .wdata_out(wdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Data word with odd parity over each half.
    function automatic logic [27:0] dword(input logic [25:0] v);
        return {~^v[25:13], ~^v[12:0], v};
    endfunction : dword

    task automatic give_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Access through the model; a used-up wait ends the run.
    task automatic acc(input logic w, ins, bk, dup, input logic [14:0] a,
                       input logic [27:0] d);
        pm.access(w, ins, bk, dup, a, d);
        if (pm.timed_out)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask : acc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        `CHK({done, err, fixed, dup_o, tmr_err}, 5'h00)
        `CHK(rdata, 28'h0000000)
    endtask : t_reset

    // Both arithmetic units loaded in one cycle, results one later.
    task automatic t_arith;
        @(posedge clk_in);
        #1;
        {add_a_in, add_b_in, add_sub_in} = {26'h3FFFFFF, 26'h0000001, 1'b0};
        {mul_a_in, mul_b_in} = {13'h1FFF, 13'h1FFF};
        @(posedge clk_in);
        #1;
        `CHK(add_o, 26'h0000000)
        `CHK(mul_o, 26'h3FFC001)
        {add_a_in, add_b_in, add_sub_in} = {26'h0000005, 26'h0000007, 1'b1};
        @(posedge clk_in);
        #1;
        `CHK(add_o, 26'h3FFFFFE)
    endtask : t_arith

    // Duplex write lands in both modules; serial readout LSB first.
    task automatic t_duplex;
        logic [27:0] w;
        w = dword(26'h2AAAAAA);
        acc(1'b1, 1'b0, 1'b0, 1'b1, 15'h7FFF, w);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 15'h7FFF, '0);
        `CHK(rdata, w)
        acc(1'b0, 1'b0, 1'b1, 1'b0, 15'h7FFF, '0);
        `CHK(rdata, w)
        acc(1'b0, 1'b0, 1'b1, 1'b1, 15'h7FFF, '0);
        `CHK({rdata, err, fixed, dup_o}, {w, 3'h1})
        `CHK(pm.nbits, 28)
        `CHK(pm.bits, w)
    endtask : t_duplex

    // Simplex modules hold distinct words; bad parity is only flagged.
    task automatic t_simplex;
        logic [27:0] w1, w2;
        w1 = dword(26'h1234567);
        w2 = dword(26'h0FEDCBA);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 15'h0000, w1);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 15'h0000, w2);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 15'h0000, '0);
        `CHK(rdata, w1)
        acc(1'b0, 1'b0, 1'b1, 1'b0, 15'h0000, '0);
        `CHK(rdata, w2)
        acc(1'b1, 1'b0, 1'b0, 1'b0, 15'h0001, w1 ^ 28'h0000001);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 15'h0001, '0);
        `CHK({err, fixed}, 2'h2)
        `CHK(rdata, w1 ^ 28'h0000001)
    endtask : t_simplex

    // Corrupt one module, then a duplex read repairs it from the mate.
    task automatic t_repair;
        logic [27:0] w;
        w = dword(26'h3C3C3C3);
        acc(1'b1, 1'b0, 1'b0, 1'b1, 15'h0002, w);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 15'h0002, w ^ 28'h4000000);
        acc(1'b0, 1'b0, 1'b0, 1'b1, 15'h0002, '0);
        `CHK({rdata, err, fixed}, {w, 2'h1})
        acc(1'b0, 1'b0, 1'b0, 1'b0, 15'h0002, '0);
        `CHK({rdata, err, fixed, dup_o}, {w, 3'h0})
    endtask : t_repair

    // Instruction path addresses the same store through its own address.
    task automatic t_instr;
        logic [27:0] w;
        w = dword({12'h000, ~^13'h0ABC, 13'h0ABC});
        acc(1'b1, 1'b1, 1'b0, 1'b1, 15'h1234, w);
        acc(1'b0, 1'b0, 1'b0, 1'b1, 15'h1234, '0);
        `CHK(rdata, w)
        acc(1'b0, 1'b1, 1'b0, 1'b1, 15'h1234, '0);
        `CHK({rdata[13:0], err}, {w[13:0], 1'b0})
    endtask : t_instr

    // Spacing of bit ticks gives the bit time.
    task automatic t_tick;
        int n, gap;
        gap = 0;
        for (n = 0; n < 400 && tick !== 1'b1; n++)
        begin
            @(posedge clk_in);
            #1;
        end
        for (n = 0; n < 400 && gap == 0; n++)
        begin
            @(posedge clk_in);
            #1;
            if (tick === 1'b1)
                gap = n + 1;
        end
        `CHK(gap, dcmc_pkg::BIT_CYC)
    endtask : t_tick

    // Voted state walks read then shift during an access, with no flag.
    task automatic t_voter;
        int         i;
        logic [2:0] exp_st;
        fork
            acc(1'b0, 1'b0, 1'b0, 1'b1, 15'h7FFF, '0);
            begin
                @(posedge clk_in);
                #1;
                for (i = 0; i < 8; i++)
                begin
                    @(posedge clk_in);
                    #1;
                    exp_st = (i == 0) ? dcmc_pkg::DCMC_READ
                                      : dcmc_pkg::DCMC_SHIFT;
                    `CHK(dut.vote_state, exp_st)
                    `CHK(tmr_err, 1'b0)
                end
            end
        join
        `CHK(rdata, dword(26'h2AAAAAA))
    endtask : t_voter

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_in);
        #1;
        t_reset();
        resetn_in = 1'b1;
        t_arith();
        t_duplex();
        t_simplex();
        t_repair();
        t_instr();
        t_tick();
        t_voter();
        give_verdict();
    end
endmodule : test_duplex_core_memory_control
